// File: hw/airs_top.sv
// module: input/reference select register with AHB-Lite slave and conversion hold-off
`timescale 1ns/1ns
module airs_top (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic                    conv_start,
  input  wire logic                    conversion_done_flag,
  input  wire logic [9:0]              conv_result,
  output logic      [15:0]             data_out,
  output airs_pkg::airs_route_type     route,
  output logic      [4:0]              conv_len
);

  airs_pkg::airs_regs_type r_q;
  airs_pkg::airs_regs_type r_d;

  //----------------------------------------------------------------
  // decode helpers
  //----------------------------------------------------------------
  function automatic airs_pkg::airs_route_type decode(input logic [7:0] s, input logic ext);
    airs_pkg::airs_route_type o;
    logic [2:0] pr;
    o = '0;
    pr = s[3:1];
    if (!s[airs_pkg::airs_ref_lo_bit])
      o.ref_sel = ext ? airs_pkg::airs_ref_pin : airs_pkg::airs_ref_supply;
    else
      o.ref_sel = s[airs_pkg::airs_ref_hi_bit] ? airs_pkg::airs_ref_int_2v56
                                               : airs_pkg::airs_ref_int_1v1;
    if (s[4]) begin
      o.src       = airs_pkg::airs_src_diff;
      o.pos_input = {1'b0, pr} + ((pr >= 3'h3) ? 4'h1 : 4'h0) + ((pr >= 3'h6) ? 4'h1 : 4'h0);
      o.neg_input = o.pos_input + 4'h1;
      o.gain_20x  = s[0];
    end else begin
      o.pos_input = s[3:0];
      unique case (s[3:0])
        4'hb:    o.src = airs_pkg::airs_src_temp;
        4'hc:    o.src = airs_pkg::airs_src_bandgap;
        4'hd:    o.src = airs_pkg::airs_src_supply4;
        4'he:    o.src = airs_pkg::airs_src_ground;
        4'hf:    o.src = airs_pkg::airs_src_reserved;
        default: o.src = airs_pkg::airs_src_single;
      endcase
    end
    return o;
  endfunction : decode

  //----------------------------------------------------------------
  // next state
  //----------------------------------------------------------------
  logic        addr_ok;
  logic        wr_sel;
  logic        wr_misc;
  logic [7:0]  new_sel;
  logic [15:0] cur_res;
  logic        ref_chg;

  always_comb begin
    r_d = r_q;
    addr_ok = hsel && hready && htrans[1];
    wr_sel  = r_q.bus_sel && r_q.bus_wr && r_q.bus_addr == airs_pkg::airs_sel_addr;
    wr_misc = r_q.bus_sel && r_q.bus_wr && r_q.bus_addr == airs_pkg::airs_misc_addr;
    new_sel = hwdata[7:0];
    // enable flips count as reference changes too
    ref_chg = (wr_sel && new_sel[7:6] != r_q.sel[7:6])
              || (wr_misc && hwdata[0] != r_q.ext_pin_en);
    if (addr_ok) begin
      r_d.bus_sel  = 1'b1;
      r_d.bus_wr   = hwrite;
      r_d.bus_addr = haddr[7:0];
    end else if (hready) begin
      r_d.bus_sel = 1'b0;
    end
    if (wr_sel) begin
      r_d.sel = new_sel;
      if (new_sel[7:6] != r_q.sel[7:6])
        r_d.ref_changed = 1'b1;
    end
    if (wr_misc) begin
      if (hwdata[0] != r_q.ext_pin_en)
        r_d.ref_changed = 1'b1;
      r_d.ext_pin_en = hwdata[0];
    end
    unique case (r_q.st)
      airs_pkg::airs_st_idle: begin
        if (conv_start) begin
          r_d.eff_sel = r_d.sel;
          r_d.eff_ext = r_d.ext_pin_en;
          // 25 only after a reference change
          r_d.conv_len = r_q.ref_changed ? airs_pkg::airs_len_init
                                         : airs_pkg::airs_len_normal;
          // a change written in the start cycle is owed to the next conversion
          r_d.ref_changed = ref_chg;
          r_d.st = airs_pkg::airs_st_conv;
        end
      end
      airs_pkg::airs_st_conv: begin
        if (conversion_done_flag)
          r_d.st = airs_pkg::airs_st_idle;
      end
    endcase
    if (r_q.st == airs_pkg::airs_st_idle && !conv_start) begin
      r_d.eff_sel = r_d.sel;
      r_d.eff_ext = r_d.ext_pin_en;
    end
    r_d.route = decode(r_d.eff_sel, r_d.eff_ext);
    cur_res = r_d.sel[airs_pkg::airs_left_bit] ? {conv_result, 6'h00} : {6'h00, conv_result};
    r_d.data_out = cur_res;
    r_d.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        airs_pkg::airs_sel_addr:  r_d.rdata = {24'h00_0000, r_d.sel};
        airs_pkg::airs_misc_addr: r_d.rdata = {31'h0000_0000, r_d.ext_pin_en};
        airs_pkg::airs_eff_addr:  r_d.rdata = {22'h00_0000, r_q.st == airs_pkg::airs_st_conv,
                                               r_q.ref_changed, r_d.eff_sel};
        default:                  r_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q          <= '0;
      r_q.sel      <= airs_pkg::airs_sel_reset;
      r_q.st       <= airs_pkg::airs_st_idle;
      r_q.conv_len <= airs_pkg::airs_len_normal;
    end else begin
      r_q <= r_d;
    end
  end

  assign hrdata    = r_q.rdata;
  // zero wait states: every register answers in the cycle after its address
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign data_out  = r_q.data_out;
  assign route     = r_q.route;
  assign conv_len  = r_q.conv_len;

  //----------------------------------------------------------------
  // checks
  //----------------------------------------------------------------
  a_hold_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.st == airs_pkg::airs_st_conv && !conversion_done_flag |=> $stable(r_q.eff_sel))
    else $error("selection changed during conversion");
  a_hold_ref: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.st == airs_pkg::airs_st_conv |=> $stable(r_q.eff_ext))
    else $error("reference pin enable changed during conversion");
  a_init_len: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.st == airs_pkg::airs_st_idle && conv_start && r_q.ref_changed
    |=> conv_len == airs_pkg::airs_len_init)
    else $error("conversion after reference change not 25");
  a_norm_len: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.st == airs_pkg::airs_st_idle && conv_start && !r_q.ref_changed
    |=> conv_len == airs_pkg::airs_len_normal)
    else $error("normal conversion not 13");
  a_left_al: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ($past(hresetn) && $past(r_d.sel[5])) |-> data_out[15:6] == $past(conv_result))
    else $error("left alignment wrong");
  a_right_al: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ($past(hresetn) && !$past(r_d.sel[5])) |-> data_out[9:0] == $past(conv_result))
    else $error("right alignment wrong");
  a_ref_dec: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.eff_sel[7:6] == 2'h3 |-> route.ref_sel == airs_pkg::airs_ref_int_2v56)
    else $error("2.56V reference not decoded");
  a_diff_dec: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.eff_sel[4] |-> route.src == airs_pkg::airs_src_diff
                       && route.gain_20x == r_q.eff_sel[0])
    else $error("differential decode wrong");
  a_temp_dec: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.eff_sel[4:0] == 5'h0b |-> route.src == airs_pkg::airs_src_temp)
    else $error("temperature code wrong");
  a_done_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.st == airs_pkg::airs_st_conv && conversion_done_flag |=> r_q.st == airs_pkg::airs_st_idle)
    else $error("conversion did not end on done");
  a_latch_start: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.st == airs_pkg::airs_st_idle && conv_start && !wr_sel |=> r_q.eff_sel == $past(r_q.sel))
    else $error("selection not latched at start");
  a_ref_supply: assert property (@(posedge hclk) disable iff (!hresetn)
    !r_q.eff_sel[6] && !r_q.eff_ext |-> route.ref_sel == airs_pkg::airs_ref_supply)
    else $error("supply reference not decoded");
  a_ref_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    !r_q.eff_sel[6] && r_q.eff_ext |-> route.ref_sel == airs_pkg::airs_ref_pin)
    else $error("pin reference not decoded");
  a_ref_band: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.eff_sel[7:6] == 2'h1 |-> route.ref_sel == airs_pkg::airs_ref_int_1v1)
    else $error("1.1V reference not decoded");
  a_single_dec: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.eff_sel[4:0] <= 5'h0a
    |-> route.src == airs_pkg::airs_src_single && route.pos_input == r_q.eff_sel[3:0])
    else $error("single ended code wrong");
  a_ground_dec: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.eff_sel[4:0] == 5'h0e |-> route.src == airs_pkg::airs_src_ground)
    else $error("ground code wrong");
  a_resv_dec: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.eff_sel[4:0] == 5'h0f |-> route.src == airs_pkg::airs_src_reserved)
    else $error("reserved code wrong");
  a_last_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.eff_sel[4:1] == 4'hf |-> route.pos_input == 4'h9 && route.neg_input == 4'ha)
    else $error("last differential pair wrong");
  a_len_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    r_q.st == airs_pkg::airs_st_conv |=> $stable(conv_len))
    else $error("conversion length changed during conversion");

endmodule : airs_top

// File: hw/airs_pkg.sv
// package: register map, field layout and decode constants for the input/reference select block
//----------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------
// Functional notes
// - reference from select bits and external enable: supply, pin, 1.1V, 2.56V.
// - reference rewrite during conversion takes effect only after completion flag sets.
// - any reference-select change makes the next conversion last 25 converter clocks; a change written in the start cycle is owed to the conversion after.
// - left-align bit five set gives left aligned result, clear gives right aligned.
// - changing left-align re-presents result immediately, even during a conversion.
// - channel/gain rewrite during conversion takes effect only after completion flag sets.
// - codes 0..10 single ended, then temperature, bandgap, supply/4, ground, reserved.
// - codes 1xxxx select differential pair by bits 3:1, gain 8x or 20x by bit 0.
// - completion flag sets when a conversion finishes and result is updated.
// - normal conversion 13 converter clocks; 25 only when re-initialisation needed.
package airs_pkg;

  //----------------------------------------------------------------
  // register map
  //----------------------------------------------------------------
  localparam logic [7:0] airs_sel_addr   = 8'h7c;
  localparam logic [7:0] airs_misc_addr  = 8'h80;
  localparam logic [7:0] airs_eff_addr   = 8'h84;
  localparam logic [7:0] airs_sel_reset  = 8'h00;
  localparam int         airs_left_bit   = 5;
  localparam int         airs_ref_hi_bit = 7;
  localparam int         airs_ref_lo_bit = 6;
  localparam logic [4:0] airs_len_normal = 5'h0d;
  localparam logic [4:0] airs_len_init   = 5'h19;

  //----------------------------------------------------------------
  // decode codes
  //----------------------------------------------------------------
  typedef enum logic [1:0] {
    airs_ref_supply   = 2'h0,
    airs_ref_pin      = 2'h1,
    airs_ref_int_1v1  = 2'h2,
    airs_ref_int_2v56 = 2'h3
  } airs_ref_type;

  typedef enum logic [2:0] {
    airs_src_single   = 3'h0,
    airs_src_temp     = 3'h1,
    airs_src_bandgap  = 3'h2,
    airs_src_supply4  = 3'h3,
    airs_src_ground   = 3'h4,
    airs_src_reserved = 3'h5,
    airs_src_diff     = 3'h6
  } airs_src_type;

  typedef struct packed {
    airs_ref_type ref_sel;
    airs_src_type src;
    logic [3:0]   pos_input;
    logic [3:0]   neg_input;
    logic         gain_20x;
  } airs_route_type;

  typedef enum logic [1:0] {
    airs_st_idle = 2'b01,
    airs_st_conv = 2'b10
  } airs_state_type;

  typedef struct packed {
    logic [7:0]     sel;
    logic           ext_pin_en;
    logic           ref_changed;
    airs_state_type st;
    logic [7:0]     eff_sel;
    logic           eff_ext;
    logic           bus_wr;
    logic           bus_sel;
    logic [7:0]     bus_addr;
    logic [31:0]    rdata;
    logic [15:0]    data_out;
    airs_route_type route;
    logic [4:0]     conv_len;
  } airs_regs_type;

endpackage : airs_pkg

// File: test/tb_top.sv
// testbench: register access, decode, hold-off and alignment of the select block
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [7:0] sel;
    logic       ext;
    logic [1:0] rf;
    logic [2:0] src;
    logic [3:0] pos;
  } airs_row_type;
  logic                     hclk;
  logic                     hresetn;
  logic                     hsel;
  logic [31:0]              haddr;
  logic [1:0]               htrans;
  logic                     hwrite;
  logic [31:0]              hwdata;
  logic [31:0]              hrdata;
  logic                     hreadyout;
  logic                     hresp;
  logic                     conv_start;
  logic                     done;
  logic [9:0]               result;
  logic [15:0]              data_out;
  logic [4:0]               conv_len;
  airs_pkg::airs_route_type route;
  int                       error_cnt;
  int                       num_checks;
  int                       cycles;
  logic [31:0]              rd;
  logic [3:0]               pairs [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
  airs_row_type             rows [9] = '{
    '{8'h00, 1'h0, 2'h0, 3'h0, 4'h0}, '{8'h00, 1'h1, 2'h1, 3'h0, 4'h0},
    '{8'h4a, 1'h0, 2'h2, 3'h0, 4'ha}, '{8'hcb, 1'h0, 2'h3, 3'h1, 4'h0},
    '{8'h8c, 1'h0, 2'h0, 3'h2, 4'h0}, '{8'h8d, 1'h1, 2'h1, 3'h3, 4'h0},
    '{8'h6e, 1'h0, 2'h2, 3'h4, 4'h0}, '{8'h0f, 1'h0, 2'h0, 3'h5, 4'h0},
    '{8'h05, 1'h0, 2'h0, 3'h0, 4'h5}};

  airs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start),
    .conversion_done_flag(done), .conv_result(result), .data_out(data_out),
    .route(route), .conv_len(conv_len));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  //----------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  // address phase held until hready, then data phase; read data taken at its end
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  task automatic pulse(input logic start);
    @(posedge hclk);
    if (start) conv_start <= 1'b1; else done <= 1'b1;
    @(posedge hclk);
    conv_start <= 1'b0;
    done       <= 1'b0;
    tick(2);
  endtask : pulse

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // a hang costs one mismatch; the whole run needs under 300 cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  //----------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, conv_start, done, result} = '0;
    tick(4);
    hresetn <= 1'b1;
    tick(2);
    chk("conv_len reset", 32'h0000_000d, conv_len);
    chk("data_out reset", 32'h0000_0000, data_out);
    ahb(1'b0, 32'h0000_007c, 32'h0000_0000);
    chk("sel reset", 32'h0000_0000, rd);
    chk("hresp okay", 32'h0000_0000, hresp);
    foreach (rows[i]) begin
      ahb(1'b1, 32'h0000_0080, {31'h0, rows[i].ext});
      ahb(1'b1, 32'h0000_007c, {24'h0, rows[i].sel});
      tick(3);
      chk("ref_sel", rows[i].rf, route.ref_sel);
      chk("src", rows[i].src, route.src);
      if (rows[i].src == 3'h0) chk("pos", rows[i].pos, route.pos_input);
    end
    for (int c = 16; c < 32; c++) begin
      ahb(1'b1, 32'h0000_007c, c);
      tick(3);
      chk("diff src", 32'h0000_0006, route.src);
      chk("diff pos", pairs[c[3:1]], route.pos_input);
      chk("diff neg", pairs[c[3:1]] + 4'h1, route.neg_input);
      chk("diff gain", c[0], route.gain_20x);
    end
    ahb(1'b1, 32'h0000_007c, 32'hffff_ffa5);
    ahb(1'b0, 32'h0000_007c, 32'h0000_0000);
    chk("sel readback", 32'h0000_00a5, rd);
    ahb(1'b0, 32'h0000_0090, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    // first conversion absorbs the earlier reference changes
    pulse(1'b1);
    pulse(1'b0);
    pulse(1'b1);
    chk("len plain", 32'h0000_000d, conv_len);
    pulse(1'b0);
    ahb(1'b1, 32'h0000_007c, 32'h0000_0040);
    pulse(1'b1);
    chk("len ref change", 32'h0000_0019, conv_len);
    pulse(1'b0);
    ahb(1'b1, 32'h0000_0080, 32'h0000_0001);
    pulse(1'b1);
    chk("len pin enable", 32'h0000_0019, conv_len);
    pulse(1'b0);
    ahb(1'b1, 32'h0000_0080, 32'h0000_0000);
    pulse(1'b1);
    ahb(1'b1, 32'h0000_007c, 32'h0000_00d3);
    tick(3);
    ahb(1'b0, 32'h0000_0084, 32'h0000_0000);
    chk("status busy", 32'h0000_0340, rd);
    chk("held ref", 32'h0000_0002, route.ref_sel);
    chk("held src", 32'h0000_0000, route.src);
    result <= 10'h2b5;
    pulse(1'b0);
    chk("new ref", 32'h0000_0003, route.ref_sel);
    chk("new src", 32'h0000_0006, route.src);
    chk("new pos", 32'h0000_0001, route.pos_input);
    chk("right align", 32'h0000_02b5, data_out);
    pulse(1'b1);
    ahb(1'b1, 32'h0000_007c, 32'h0000_00f3);
    tick(2);
    chk("left align", 32'h0000_ad40, data_out);
    ahb(1'b1, 32'h0000_007c, 32'h0000_00d3);
    tick(2);
    chk("right again", 32'h0000_02b5, data_out);
    pulse(1'b0);
    // reset in mid-run: the conv_len of 25 and the selection must be gone
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(2);
    chk("conv_len rst2", 32'h0000_000d, conv_len);
    chk("route rst2", 32'h0000_0000, route);
    chk("data_out rst2", 32'h0000_02b5, data_out);
    ahb(1'b0, 32'h0000_0084, 32'h0000_0000);
    chk("status rst2", 32'h0000_0000, rd);
    final_report();
  end
endmodule : tb_top
